/* rtl/pll_front_pkg.sv */
// constants, register map and carrier types for the pll reference front end
package pll_front_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_STATUS    = 8'h00;
   localparam logic [7:0] IDX_STAT_SEL  = 8'h01;
   localparam logic [7:0] IDX_REF_CFG   = 8'h02;
   localparam logic [7:0] IDX_DIV_HI    = 8'h06;
   localparam logic [7:0] IDX_DIV_LO    = 8'h07;
   localparam logic [7:0] IDX_PUMP_CUR  = 8'h0a;
   localparam logic [7:0] IDX_PUMP_CTL  = 8'h0b;
   localparam int         ADDR_LSB      = 2;

   // status bit positions (register 0 and status pin select)
   localparam int ST_REF_PRESENT = 0;
   localparam int ST_REF_ABSENT  = 1;
   localparam int ST_LOCK        = 2;
   localparam int ST_LOCK_N      = 3;
   localparam int ST_UNLOCK      = 4;
   localparam int ST_W           = 5;

   // reference config fields
   localparam int RC_LOWPASS  = 0;
   localparam int RC_BOOST    = 1;
   localparam int RC_DET_PD   = 2;
   // divider high register fields
   localparam int DH_RD_LSB   = 0;       // ratio bits 9:8 in 1:0
   localparam int DH_WIN      = 2;
   localparam int DH_CNT_LSB  = 3;       // count select in 4:3
   localparam int DH_ALIGN    = 5;
   // pump control fields
   localparam int PC_RESET    = 0;
   localparam int PC_SOURCE   = 1;
   localparam int PC_SINK     = 2;

   localparam int          RD_W          = 10;
   localparam logic [9:0]  RD_RESET      = 10'h001;
   localparam logic [4:0]  CP_RESET      = 5'h00;
   localparam logic [4:0]  CP_MAX_VALID  = 5'h13;   // code 19
   localparam logic [ST_W-1:0] STAT_SEL_RESET = 5'h04;

   // lock count targets
   localparam logic [11:0] CNT_32   = 12'h020;
   localparam logic [11:0] CNT_256  = 12'h100;
   localparam logic [11:0] CNT_2048 = 12'h800;

   // lock window times against the system clock
   localparam int CLK_PERIOD_PS  = 20000;
   localparam int WIN_NARROW_PS  = 3000;
   localparam int WIN_WIDE_PS    = 10000;

   // longest time rounded down, never under one cycle
   function automatic logic [3:0] max_cycles(input int t_ps);
      int c;
      c = t_ps / CLK_PERIOD_PS;
      if (c < 1) c = 1;
      return 4'(c);
   endfunction

   localparam logic [3:0] WIN_NARROW_CYC = max_cycles(WIN_NARROW_PS);
   localparam logic [3:0] WIN_WIDE_CYC   = max_cycles(WIN_WIDE_PS);

   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic [1:0] {
      PFD_IDLE = 2'b00,
      PFD_SRC  = 2'b01,
      PFD_SNK  = 2'b10
   } pfd_state_t;

   typedef struct packed {
      logic       lowpass;
      logic       boost;
      logic       det_pd;
      logic       align_en;
      logic [1:0] cnt_sel;
      logic       win_sel;
      logic [9:0] ratio;
      logic [4:0] cp_code;
      logic       pfd_reset;
      logic       force_src;
      logic       force_snk;
      logic [ST_W-1:0] stat_sel;
   } cfg_t;

   typedef struct packed {
      logic ref_present;
      logic lock;
      logic unlock;
   } status_t;
endpackage

/* rtl/pll_ref_divider_lock_detect.sv */
// reference divider, phase/frequency detector, lock indicator and register slave
//
// The register offsets and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
// Function
// - ten-bit reference divider, ratio 1 to 1023
// - ratio taken directly from two registers
// - sync request edge realigns divider when enabled
// - detector pulses follow reference/feedback phase difference
// - detector reset bit blocks all detector pulses
// - count select zero disables lock indicator
// - codes select 32, 256, 2048 comparisons
// - lock after enough successive in-window comparisons
// - window select picks 3ns or 10ns, both of which become one 20ns clock cycle
// - out of window sets unlock, clears lock
// - unlock clears once back inside window
// - inverted lock flag, readable and on pin
// - presence flag switches with hysteresis thresholds
// - absent flag complements present, readable, pin
// - detector power-down disables presence detection
// - five-bit pump current code, 20-31 invalid
// - filter, boost, power-down share one register
// - status pin ORs selected status flags
module pll_ref_divider_lock_detect (
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        ref_in,
   input  wire logic        fb_div_in,
   input  wire logic        sync_request_input,
   input  wire logic        ref_level_high,
   input  wire logic        ref_level_low,
   output logic             ref_div_out,
   output logic             pump_up,
   output logic             pump_dn,
   output logic [4:0]       pump_current_code,
   output logic             ref_lowpass_enable,
   output logic             ref_gain_boost,
   output logic             ref_detector_powerdown,
   output logic             status_pin
);
   // reset release through two flops
   logic rst_meta_q, rst_sync_q;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end
   wire rst_i_n = rst_sync_q;

   // pin synchronisers, first stage read only by second
   logic [4:0] pin_meta_q, pin_sync_q, pin_prev_q;
   always_ff @(posedge clk_sys or negedge rst_i_n) begin
      if (!rst_i_n) begin
         pin_meta_q <= 5'h00;
         pin_sync_q <= 5'h00;
         pin_prev_q <= 5'h00;
      end else begin
         pin_meta_q <= {ref_level_low, ref_level_high, sync_request_input, fb_div_in, ref_in};
         pin_sync_q <= pin_meta_q;
         pin_prev_q <= pin_sync_q;
      end
   end
   wire ref_rise  = pin_sync_q[0] & ~pin_prev_q[0];
   wire fb_rise   = pin_sync_q[1] & ~pin_prev_q[1];
   wire sync_rise = pin_sync_q[2] & ~pin_prev_q[2];
   wire lvl_high  = pin_sync_q[3];
   wire lvl_low   = pin_sync_q[4];

   pll_front_pkg::cfg_t    cfg_q;
   pll_front_pkg::status_t st_q;

   // ---------------- axi4-lite slave ----------------
   logic       aw_held_q, w_held_q;
   logic [7:0] aw_idx_q;
   logic [7:0] w_data_q;
   logic       w_lane_q;
   wire aw_take = s_axi_awvalid & s_axi_awready;
   wire w_take  = s_axi_wvalid & s_axi_wready;
   wire do_wr   = aw_held_q & w_held_q & ~s_axi_bvalid;
   wire wr_hit  = (aw_idx_q == pll_front_pkg::IDX_STAT_SEL) | (aw_idx_q == pll_front_pkg::IDX_REF_CFG) |
                  (aw_idx_q == pll_front_pkg::IDX_DIV_HI) | (aw_idx_q == pll_front_pkg::IDX_DIV_LO) |
                  (aw_idx_q == pll_front_pkg::IDX_PUMP_CUR) | (aw_idx_q == pll_front_pkg::IDX_PUMP_CTL) |
                  (aw_idx_q == pll_front_pkg::IDX_STATUS);
   wire wr_en   = do_wr & w_lane_q;

   // address and data are taken in either order, then answered
   always_ff @(posedge clk_sys or negedge rst_i_n) begin
      if (!rst_i_n) begin
         aw_held_q     <= 1'b0;
         w_held_q      <= 1'b0;
         aw_idx_q      <= 8'h00;
         w_data_q      <= 8'h00;
         w_lane_q      <= 1'b0;
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= pll_front_pkg::RESP_OKAY;
      end else begin
         if (aw_take) begin
            aw_held_q     <= 1'b1;
            aw_idx_q      <= {2'b00, s_axi_awaddr[7:pll_front_pkg::ADDR_LSB]};
            s_axi_awready <= 1'b0;
         end
         if (w_take) begin
            w_held_q     <= 1'b1;
            w_data_q     <= s_axi_wdata[7:0];
            w_lane_q     <= s_axi_wstrb[0];
            s_axi_wready <= 1'b0;
         end
         if (do_wr) begin
            aw_held_q    <= 1'b0;
            w_held_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? pll_front_pkg::RESP_OKAY : pll_front_pkg::RESP_SLVERR;
         end
         if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // configuration registers
   always_ff @(posedge clk_sys or negedge rst_i_n) begin
      if (!rst_i_n) begin
         cfg_q          <= '0;
         cfg_q.ratio    <= pll_front_pkg::RD_RESET;
         cfg_q.cp_code  <= pll_front_pkg::CP_RESET;
         cfg_q.stat_sel <= pll_front_pkg::STAT_SEL_RESET;
      end else if (wr_en) begin
         case (aw_idx_q)
            pll_front_pkg::IDX_STAT_SEL: begin
               cfg_q.stat_sel <= w_data_q[pll_front_pkg::ST_W-1:0];
            end
            pll_front_pkg::IDX_REF_CFG: begin
               cfg_q.lowpass <= w_data_q[pll_front_pkg::RC_LOWPASS];
               cfg_q.boost   <= w_data_q[pll_front_pkg::RC_BOOST];
               cfg_q.det_pd  <= w_data_q[pll_front_pkg::RC_DET_PD];
            end
            pll_front_pkg::IDX_DIV_HI: begin
               cfg_q.ratio[9:8] <= w_data_q[pll_front_pkg::DH_RD_LSB +: 2];
               cfg_q.win_sel    <= w_data_q[pll_front_pkg::DH_WIN];
               cfg_q.cnt_sel    <= w_data_q[pll_front_pkg::DH_CNT_LSB +: 2];
               cfg_q.align_en   <= w_data_q[pll_front_pkg::DH_ALIGN];
            end
            pll_front_pkg::IDX_DIV_LO: begin
               cfg_q.ratio[7:0] <= w_data_q;
            end
            pll_front_pkg::IDX_PUMP_CUR: begin
               if (w_data_q[4:0] <= pll_front_pkg::CP_MAX_VALID) begin
                  cfg_q.cp_code <= w_data_q[4:0];
               end
            end
            pll_front_pkg::IDX_PUMP_CTL: begin
               cfg_q.pfd_reset <= w_data_q[pll_front_pkg::PC_RESET];
               cfg_q.force_src <= w_data_q[pll_front_pkg::PC_SOURCE];
               cfg_q.force_snk <= w_data_q[pll_front_pkg::PC_SINK];
            end
            default: begin
            end
         endcase
      end
   end

   wire [pll_front_pkg::ST_W-1:0] stat_vec = {st_q.unlock, ~st_q.lock, st_q.lock,
                                              ~st_q.ref_present, st_q.ref_present};
   wire [7:0] rd_idx = {2'b00, s_axi_araddr[7:pll_front_pkg::ADDR_LSB]};
   logic [7:0] rd_val;
   logic       rd_hit;
   always_comb begin
      rd_val = 8'h00;
      rd_hit = 1'b1;
      case (rd_idx)
         pll_front_pkg::IDX_STATUS:   rd_val = {3'b000, stat_vec};
         pll_front_pkg::IDX_STAT_SEL: rd_val = {3'b000, cfg_q.stat_sel};
         pll_front_pkg::IDX_REF_CFG:  rd_val = {5'b00000, cfg_q.det_pd, cfg_q.boost, cfg_q.lowpass};
         pll_front_pkg::IDX_DIV_HI:   rd_val = {2'b00, cfg_q.align_en, cfg_q.cnt_sel, cfg_q.win_sel,
                                                cfg_q.ratio[9:8]};
         pll_front_pkg::IDX_DIV_LO:   rd_val = cfg_q.ratio[7:0];
         pll_front_pkg::IDX_PUMP_CUR: rd_val = {3'b000, cfg_q.cp_code};
         pll_front_pkg::IDX_PUMP_CTL: rd_val = {5'b00000, cfg_q.force_snk, cfg_q.force_src, cfg_q.pfd_reset};
         default:                     rd_hit = 1'b0;
      endcase
   end

   // read channel, answer one cycle after the address is taken
   always_ff @(posedge clk_sys or negedge rst_i_n) begin
      if (!rst_i_n) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= pll_front_pkg::RESP_OKAY;
      end else if (s_axi_arvalid & s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= {24'h00_0000, rd_val};
         s_axi_rresp   <= rd_hit ? pll_front_pkg::RESP_OKAY : pll_front_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid & s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // ---------------- reference divider ----------------
   logic [pll_front_pkg::RD_W-1:0] div_cnt_q;
   logic                           div_pulse_q;
   wire [9:0] ratio_eff = (cfg_q.ratio == 10'h000) ? 10'h001 : cfg_q.ratio;
   // realign only with ratio of two or more
   wire realign  = cfg_q.align_en & sync_rise & (ratio_eff != 10'h001);
   wire div_wrap = ref_rise & (div_cnt_q >= ratio_eff - 10'h001);

   // counts reference edges, pulses once per ratio
   always_ff @(posedge clk_sys or negedge rst_i_n) begin
      if (!rst_i_n) begin
         div_cnt_q   <= '0;
         div_pulse_q <= 1'b0;
      end else if (realign) begin
         div_cnt_q   <= '0;
         div_pulse_q <= 1'b0;
      end else begin
         div_pulse_q <= div_wrap;
         if (div_wrap) begin
            div_cnt_q <= '0;
         end else if (ref_rise) begin
            div_cnt_q <= div_cnt_q + 10'h001;
         end
      end
   end

   // ---------------- phase/frequency detector ----------------
   pll_front_pkg::pfd_state_t pfd_q, pfd_d;
   logic [3:0] width_q;
   wire [3:0] win_cyc = cfg_q.win_sel ? pll_front_pkg::WIN_WIDE_CYC : pll_front_pkg::WIN_NARROW_CYC;
   wire       both    = div_pulse_q & fb_rise;

   // lead edge opens a pulse, lag edge closes it
   always_comb begin
      pfd_d = pfd_q;
      case (pfd_q)
         pll_front_pkg::PFD_IDLE: begin
            if (both)             pfd_d = pll_front_pkg::PFD_IDLE;
            else if (div_pulse_q) pfd_d = pll_front_pkg::PFD_SRC;
            else if (fb_rise)     pfd_d = pll_front_pkg::PFD_SNK;
         end
         pll_front_pkg::PFD_SRC: if (fb_rise) pfd_d = pll_front_pkg::PFD_IDLE;
         pll_front_pkg::PFD_SNK: if (div_pulse_q) pfd_d = pll_front_pkg::PFD_IDLE;
         default:                pfd_d = pll_front_pkg::PFD_IDLE;
      endcase
      if (cfg_q.pfd_reset) pfd_d = pll_front_pkg::PFD_IDLE;
   end

   wire active     = (pfd_q != pll_front_pkg::PFD_IDLE);
   wire cmp_done   = (active & (pfd_d == pll_front_pkg::PFD_IDLE) & ~cfg_q.pfd_reset) |
                     (~active & both & ~cfg_q.pfd_reset);
   wire cmp_width0 = ~active;
   wire out_win    = active & ~cfg_q.pfd_reset & (width_q >= win_cyc);
   wire in_win     = cmp_done & (cmp_width0 | (width_q < win_cyc));

   always_ff @(posedge clk_sys or negedge rst_i_n) begin
      if (!rst_i_n) begin
         pfd_q   <= pll_front_pkg::PFD_IDLE;
         width_q <= 4'h0;
         pump_up <= 1'b0;
         pump_dn <= 1'b0;
      end else begin
         pfd_q   <= pfd_d;
         width_q <= (pfd_d == pll_front_pkg::PFD_IDLE) ? 4'h0 :
                    (width_q == 4'hf) ? width_q : width_q + 4'h1;
         // forcing bits still reach the pump
         pump_up <= (pfd_d == pll_front_pkg::PFD_SRC) | cfg_q.force_src;
         pump_dn <= (pfd_d == pll_front_pkg::PFD_SNK) | cfg_q.force_snk;
      end
   end

   // ---------------- lock indicator ----------------
   logic [11:0] lk_cnt_q;
   wire [11:0] lk_target = (cfg_q.cnt_sel == 2'd1) ? pll_front_pkg::CNT_32 :
                           (cfg_q.cnt_sel == 2'd2) ? pll_front_pkg::CNT_256 : pll_front_pkg::CNT_2048;
   wire lk_en = (cfg_q.cnt_sel != 2'd0);

   always_ff @(posedge clk_sys or negedge rst_i_n) begin
      if (!rst_i_n) begin
         lk_cnt_q  <= 12'h000;
         st_q.lock   <= 1'b0;
         st_q.unlock <= 1'b0;
      end else if (!lk_en) begin
         lk_cnt_q    <= 12'h000;
         st_q.lock   <= 1'b0;
         st_q.unlock <= 1'b0;
      end else if (out_win) begin
         lk_cnt_q    <= 12'h000;
         st_q.lock   <= 1'b0;
         st_q.unlock <= 1'b1;
      end else if (in_win) begin
         st_q.unlock <= 1'b0;
         if (lk_cnt_q + 12'h001 >= lk_target) begin
            st_q.lock <= 1'b1;
            lk_cnt_q  <= lk_target;
         end else begin
            lk_cnt_q  <= lk_cnt_q + 12'h001;
         end
      end
   end

   // ---------------- reference presence and outputs ----------------
   // set on high threshold, clear below low threshold
   always_ff @(posedge clk_sys or negedge rst_i_n) begin
      if (!rst_i_n) begin
         st_q.ref_present <= 1'b0;
      end else if (cfg_q.det_pd) begin
         st_q.ref_present <= 1'b0;
      end else if (lvl_high) begin
         st_q.ref_present <= 1'b1;
      end else if (!lvl_low) begin
         st_q.ref_present <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_i_n) begin
      if (!rst_i_n) begin
         status_pin             <= 1'b0;
         ref_div_out            <= 1'b0;
         pump_current_code      <= pll_front_pkg::CP_RESET;
         ref_lowpass_enable     <= 1'b0;
         ref_gain_boost         <= 1'b0;
         ref_detector_powerdown <= 1'b0;
      end else begin
         status_pin             <= |(stat_vec & cfg_q.stat_sel);
         ref_div_out            <= div_pulse_q;
         pump_current_code      <= cfg_q.cp_code;
         ref_lowpass_enable     <= cfg_q.lowpass;
         ref_gain_boost         <= cfg_q.boost;
         ref_detector_powerdown <= cfg_q.det_pd;
      end
   end
endmodule // pll_ref_divider_lock_detect

/* sim/pll_front_chk.sv */
// bus and pin assertions for the pll reference front end
`timescale 1ns/1ps
module pll_front_chk (
   input wire logic        clk_sys,
   input wire logic        rst_n,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        ref_div_out,
   input wire logic [4:0]  pump_current_code
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // write answer and read answer hold until taken
   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
   r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer changed");
   b_time_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
      else $error("write answer late");
   r_time_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
   w_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken while busy");
   r_block_a: assert property (s_axi_rvalid |-> !s_axi_arready && s_axi_rdata[31:8] == 24'h0) else $error("read bad");
   r_err_a: assert property (s_axi_rvalid && s_axi_rresp == pll_front_pkg::RESP_SLVERR |-> s_axi_rdata == 32'h0)
      else $error("error read with data");
   div_pulse_a: assert property (ref_div_out |=> !ref_div_out) else $error("divider pulse too long");
   code_max_a: assert property (pump_current_code <= pll_front_pkg::CP_MAX_VALID) else $error("bad pump code");
endmodule // pll_front_chk

bind pll_ref_divider_lock_detect pll_front_chk pll_front_chk_i (.clk_sys, .rst_n, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
   .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .ref_div_out, .pump_current_code);

/* sim/ref_source_model.sv */
// reference source, feedback path and level comparators beside the front end
`timescale 1ns/1ps
module ref_source_model (
   input  wire logic       clk_sys,
   input  wire logic       skew,
   input  wire logic [1:0] amp,
   output logic            ref_in,
   output logic            fb_div_in,
   output logic            ref_level_high,
   output logic            ref_level_low
);
   logic [2:0] ph_q = 3'h0;
   logic [1:0] dly_q = 2'h0;
   // free-running reference, eight system cycles a period
   always_ff @(posedge clk_sys) begin
      ph_q  <= ph_q + 3'h1;
      dly_q <= {dly_q[0], ph_q[2]};
   end
   assign ref_in = ph_q[2];
   // feedback edge meets the registered divider pulse, or one cycle later so it leaves the window
   assign fb_div_in = skew ? dly_q[1] : dly_q[0];
   assign ref_level_high = (amp == 2'h2);
   assign ref_level_low  = (amp != 2'h0);
endmodule // ref_source_model

/* sim/test_pll_ref_divider_lock_detect.sv */
// self-checking bench for the pll reference front end
`timescale 1ns/1ps
module test_pll_ref_divider_lock_detect;
   localparam logic [1:0] OK = pll_front_pkg::RESP_OKAY;
   localparam logic [1:0] ER = pll_front_pkg::RESP_SLVERR;
   logic clk_sys = 1'b0, rst_n = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, sync_request_input = 1'b0, skew = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [1:0] amp = 2'h0, s_axi_bresp, s_axi_rresp;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, ref_in, fb_div_in;
   logic ref_level_high, ref_level_low, ref_div_out, pump_up, pump_dn, status_pin;
   logic ref_lowpass_enable, ref_gain_boost, ref_detector_powerdown;
   logic [4:0] pump_current_code;
   int n_mismatch = 0, check_count = 0;
   pll_ref_divider_lock_detect pll_ref_divider_lock_detect_i (.*);
   ref_source_model ref_source_model_i (.*);
   // system clock, 20 ns period
   always #10 clk_sys = ~clk_sys;
   task automatic final_report();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic tmo(input bit ok);
      if (!ok) begin
         n_mismatch++;
         final_report();
      end
   endtask
   task automatic wr(input logic [7:0] i, input logic [7:0] d, input logic [1:0] e);
      int n;
      @(posedge clk_sys);
      s_axi_awaddr <= {i[5:0], 2'b00};
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge clk_sys);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      s_axi_bready <= 1'b0;
      tmo(n < 20);
      chk({30'h0, s_axi_bresp}, {30'h0, e});
   endtask
   task automatic rd(input logic [7:0] i, input logic [7:0] d, input logic [1:0] e);
      int n;
      @(posedge clk_sys);
      s_axi_araddr <= {i[5:0], 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge clk_sys);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      s_axi_rready <= 1'b0;
      tmo(n < 20);
      chk({30'h0, s_axi_rresp}, {30'h0, e});
      chk(s_axi_rdata, {24'h0, d});
   endtask
   task automatic wait_pin(input logic v, input int lim, output int n);
      for (n = 0; n < lim; n++) begin
         @(posedge clk_sys);
         if (status_pin === v) break;
      end
      tmo(n < lim);
   endtask
   task automatic gap(output int g);
      int n;
      n = 0;
      do begin @(posedge clk_sys); n++; end while (ref_div_out !== 1'b1 && n < 9000);
      g = 0;
      do begin @(posedge clk_sys); g++; end while (ref_div_out !== 1'b1 && g < 9000);
      tmo(g < 9000);
   endtask
   task automatic t_regs();
      rd(8'h07, 8'h01, OK);
      rd(8'h01, 8'h04, OK);
      rd(8'h03, 8'h00, ER);
      wr(8'h03, 8'hff, ER);
      s_axi_wstrb <= 4'h0;
      wr(8'h01, 8'h1f, OK);
      s_axi_wstrb <= 4'hf;
      rd(8'h01, 8'h04, OK);
      wr(8'h0a, 8'h13, OK);
      wr(8'h0a, 8'h14, OK);
      chk({27'h0, pump_current_code}, 32'h13);
      rd(8'h0a, 8'h13, OK);
      wr(8'h02, 8'h03, OK);
      @(posedge clk_sys);
      chk({ref_detector_powerdown, ref_gain_boost, ref_lowpass_enable}, 3'b011);
      wr(8'h02, 8'h00, OK);
      $display("regs test done");
   endtask
   task automatic t_ref();
      int k;
      for (k = 4; k >= 0; k--) begin
         @(posedge clk_sys);
         amp <= 2'(10'b10_01_00_01_10 >> (2 * k));
         repeat (6) @(posedge clk_sys);
         rd(8'h00, (5'b11001 >> k) & 1 ? 8'h09 : 8'h0a, OK);
      end
      wr(8'h02, 8'h04, OK);
      rd(8'h00, 8'h0a, OK);
      wr(8'h02, 8'h00, OK);
      $display("presence test done");
   endtask
   task automatic t_div();
      int g;
      wr(8'h07, 8'h03, OK);
      gap(g);
      gap(g);
      chk(g, 24);
      wr(8'h06, 8'h01, OK);
      gap(g);
      gap(g);
      chk(g, 259 * 8);
      wr(8'h06, 8'h00, OK);
      wr(8'h07, 8'h01, OK);
      gap(g);
      gap(g);
      chk(g, 8);
      $display("divider test done");
   endtask
   task automatic t_sync();
      int k, r, p;
      wr(8'h06, 8'h20, OK);
      for (r = 3; r > 0; r -= 2) begin
         wr(8'h07, 8'(r), OK);
         p = 0;
         for (k = 0; k < 192; k++) begin
            @(posedge clk_sys);
            sync_request_input <= (k % 16) < 8;
            if (k >= 32) p += (ref_div_out === 1'b1);
         end
         chk(p, r == 1 ? 20 : 0);
      end
      wr(8'h06, 8'h00, OK);
      $display("sync test done");
   endtask
   task automatic t_pfd();
      int u, d;
      wr(8'h0b, 8'h05, OK);
      @(posedge clk_sys);
      skew <= 1'b1;
      u = 0;
      d = 0;
      repeat (64) begin @(posedge clk_sys); u += (pump_up === 1'b1); d += (pump_dn === 1'b1); end
      chk(u, 0);
      chk(d, 64);
      wr(8'h0b, 8'h00, OK);
      u = 0;
      d = 0;
      repeat (64) begin @(posedge clk_sys); u += (pump_up === 1'b1); d += (pump_dn === 1'b1); end
      chk({u >= 8 && u <= 24, d == 0}, 2'b11);
      $display("detector test done");
   endtask
   task automatic t_lock();
      int c, n, cnt;
      @(posedge clk_sys);
      skew <= 1'b0;
      for (c = 1; c < 4; c++) begin
         cnt = 32 << (3 * (c - 1));
         wr(8'h06, {3'h0, 2'(c), 1'(c == 2), 2'h0}, OK);
         wait_pin(1'b1, 20000, n);
         chk(n >= (cnt - 1) * 8 && n <= (cnt + 3) * 8, 1);
         rd(8'h00, 8'h05, OK);
         wr(8'h06, 8'h00, OK);
         rd(8'h00, 8'h09, OK);
      end
      wr(8'h06, 8'h08, OK);
      wait_pin(1'b1, 400, n);
      wr(8'h01, 8'h10, OK);
      @(posedge clk_sys);
      skew <= 1'b1;
      wait_pin(1'b1, 40, n);
      chk(n <= 20, 1);
      rd(8'h00, 8'h19, OK);
      @(posedge clk_sys);
      skew <= 1'b0;
      wait_pin(1'b0, 40, n);
      rd(8'h00, 8'h09, OK);
      wr(8'h01, 8'h11, OK);
      wait_pin(1'b1, 10, n);
      $display("lock test done");
   endtask
   // reset, then every scenario in turn
   initial begin
      repeat (5) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
      t_regs();
      t_ref();
      t_div();
      t_sync();
      t_pfd();
      t_lock();
      final_report();
   end
endmodule // test_pll_ref_divider_lock_detect
